// *** hdl/flash_prog_port.sv ***
// Command interpreter of the parallel flash programming port
//
// Functional notes
// [R01] Select low, prefix AAh strobed, then the command code.
// [R02] Write code page: 50h, address high, address low, data bytes.
// [R03] Page number is address bits 11 down to 5.
// [R04] Offset starts at the low five bits of the low address byte.
// [R05] Data captured on strobe rise; offset advances on strobe fall.
// [R06] Offset wraps from 31 to zero in the same page.
// [R07] Programmer gives 1 to 32 bytes, no reload, no skip.
// [R08] Select high right after address programs only buffered data.
// [R09] Programmer waits 2 ms or watches busy after a page write.
// [R10] Read code page: 30h, address high, address low on fourth strobe.
// [R11] Read data driven after the fourth strobe falls.
// [R12] Programmer releases the bus before the fourth strobe falls.
// [R13] Each further read strobe presents the next byte.
// [R14] Write user signature: 52h, 00h, offset, data bytes.
// [R15] Programmer enables the user row fuse before signature writes.
// [R16] Read user signature: 32h, 00h, offset, successive bytes.
// [R17] Read maker signature: 38h, 00h, offset, successive bytes.
// [R18] Write lock bits: E4h, 00h, 00h, one data byte.
// [R19] Write user fuses: E1h, 00h, 00h, one data byte.
// [R20] Programmer writes unimplemented fuse bits as one.
// [R21] Programmer waits 4 ms or watches busy after lock or fuse writes.
// [R22] Lock read 64h, fuse read 61h, two 00h, status after fourth fall.
// [R23] Select high resets the interpreter and releases the bus.
// [R24] Ready/busy low while programming.
// [R25] Busy read of the last written byte inverts its MSB.
// [R26] Non-prefix first byte ignored until select rises.
`timescale 1ns/100ps
`default_nettype none
`include "flash_prog_map.svh"

module flash_prog_port
   import flash_prog_pkg::*;
#(
   parameter int PAGE_BYTES = 32
) (
   input  wire logic                          REF_CLK,
   input  wire logic                          RST,
   input  wire logic                          SELECT_PIN_N,
   input  wire logic                          BYTE_STROBE,
   input  wire logic [7:0]                    COMMAND_BUS_IN,
   output var  logic [7:0]                    COMMAND_BUS_OUT,
   output var  logic                          COMMAND_BUS_OE,
   output var  logic                          READY_BUSY_OUT,
   input  wire logic                          ARRAY_BUSY,
   output var  logic                          RD_REQ,
   output var  target_e                       RD_TARGET,
   output var  logic [6:0]                    RD_PAGE,
   output var  logic [$clog2(PAGE_BYTES)-1:0] RD_OFFSET,
   input  wire logic [7:0]                    RD_DATA,
   input  wire logic [7:0]                    LOCK_STATE,
   input  wire logic [7:0]                    FUSE_STATE,
   output var  logic                          PROG_VALID,
   input  wire logic                          PROG_READY,
   output var  target_e                       PROG_TARGET,
   output var  logic [6:0]                    PROG_PAGE,
   output var  logic [$clog2(PAGE_BYTES)-1:0] PROG_OFFSET,
   output var  logic [7:0]                    PROG_DATA,
   output var  logic                          PROG_LAST
);

   localparam int OW = $clog2(PAGE_BYTES);
   localparam int BW = 3 + 7 + OW + 8 + 1;

   // Offset wrap relies on a natural power-of-two counter
   if (PAGE_BYTES < 2 || PAGE_BYTES > 32 || (PAGE_BYTES & (PAGE_BYTES - 1)) != 0) begin : g_bad_size
      $error("PAGE_BYTES must be a power of two from 2 to 32");
   end

   // ==========
   // Strobe and select edges
   logic sel_n_r;
   logic strb_r;

   wire strb_rise = BYTE_STROBE && !strb_r;
   wire strb_fall = !BYTE_STROBE && strb_r;
   wire sel_rise  = SELECT_PIN_N && !sel_n_r;
   wire byte_in   = !SELECT_PIN_N && strb_rise;
   wire byte_out  = !SELECT_PIN_N && strb_fall;

   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         sel_n_r <= 1'b1;
         strb_r  <= 1'b0;
      end else begin
         sel_n_r <= SELECT_PIN_N;
         strb_r  <= BYTE_STROBE;
      end
   end

   // ==========
   // Command state
   cmd_state_e          st_r;
   cmd_state_e          st_nxt;
   logic [7:0]          code_r;
   target_e             tgt_r;
   logic [7:0]          hi_r;
   logic [6:0]          page_r;
   logic [OW-1:0]       offset_r;
   logic                arm_r;
   logic [PAGE_BYTES-1:0] mask_r;
   drain_state_e        d_st_r;
   logic [OW-1:0]       scan_r;
   target_e             dr_tgt_r;
   logic [6:0]          dr_page_r;
   logic                rd_wait_r;
   logic                rd_status_r;
   target_e             last_tgt_r;
   logic [6:0]          last_page_r;
   logic [OW-1:0]       last_off_r;
   logic [7:0]          last_data_r;

   wire buf_out_valid;
   wire buf_in_ready;
   wire [7:0] mem_rd_data;
   wire [BW-1:0] buf_out;

   wire busy = (d_st_r != D_IDLE) || buf_out_valid || ARRAY_BUSY;

   // Command code decode
   wire c_wr_code = (COMMAND_BUS_IN == `FPP_CMD_WR_CODE);
   wire c_load    = (COMMAND_BUS_IN == `FPP_CMD_LOAD_BUF);
   wire c_wr_user = (COMMAND_BUS_IN == `FPP_CMD_WR_USER);
   wire c_wr_lock = (COMMAND_BUS_IN == `FPP_CMD_WR_LOCK);
   wire c_wr_fuse = (COMMAND_BUS_IN == `FPP_CMD_WR_FUSE);
   wire c_rd_page = (COMMAND_BUS_IN == `FPP_CMD_RD_CODE) || (COMMAND_BUS_IN == `FPP_CMD_RD_USER) ||
                    (COMMAND_BUS_IN == `FPP_CMD_RD_MAKER);
   wire c_rd_stat = (COMMAND_BUS_IN == `FPP_CMD_RD_LOCK) || (COMMAND_BUS_IN == `FPP_CMD_RD_FUSE);
   wire c_write   = c_wr_code || c_load || c_wr_user || c_wr_lock || c_wr_fuse;
   wire c_known   = c_write || c_rd_page || c_rd_stat;

   wire is_page_wr = (code_r == `FPP_CMD_WR_CODE) || (code_r == `FPP_CMD_WR_USER) ||
                     (code_r == `FPP_CMD_LOAD_BUF);
   wire is_page_rd = (code_r == `FPP_CMD_RD_CODE) || (code_r == `FPP_CMD_RD_USER) ||
                     (code_r == `FPP_CMD_RD_MAKER);
   wire is_one_wr  = (code_r == `FPP_CMD_WR_LOCK) || (code_r == `FPP_CMD_WR_FUSE);

   target_e tgt_dec;
   assign tgt_dec = (COMMAND_BUS_IN == `FPP_CMD_RD_USER || c_wr_user) ? TGT_USER :
                    (COMMAND_BUS_IN == `FPP_CMD_RD_MAKER)               ? TGT_MAKER :
                    (c_wr_lock || COMMAND_BUS_IN == `FPP_CMD_RD_LOCK)   ? TGT_LOCK :
                    (c_wr_fuse || COMMAND_BUS_IN == `FPP_CMD_RD_FUSE)   ? TGT_FUSE : TGT_CODE;

   // Page from address bits 11..5, offset from low bits
   wire [6:0]    page_dec = {hi_r[`FPP_PAGE_HI_MSB:0], COMMAND_BUS_IN[7:`FPP_PAGE_LO_LSB]}; // [R03]
   wire [OW-1:0] off_dec  = COMMAND_BUS_IN[OW-1:0]; // [R04]
   wire [OW-1:0] off_inc  = offset_r + 1'b1; // [R06]

   // Data capture into the page buffer
   wire data_cap  = byte_in && (st_r == S_WDATA || st_r == S_ONE); // [R05]
   wire [OW-1:0] cap_addr = (st_r == S_ONE) ? '0 : offset_r;

   // ==========================================================
   // Sequencer next state
   always_comb begin
      st_nxt = st_r;
      unique case (st_r)
         S_PREFIX: if (byte_in) st_nxt = (COMMAND_BUS_IN == `FPP_PREFIX) ? S_CODE : S_REJECT; // [R01] [R26]
         S_CODE:   if (byte_in) st_nxt = (c_known && !(c_write && busy)) ? S_HI : S_REJECT;
         S_HI:     if (byte_in) st_nxt = S_LO; // [R02] [R14]
         S_LO: begin
            if (byte_in) begin
               if (is_page_wr) begin
                  st_nxt = S_WDATA;
               end else if (is_one_wr) begin
                  st_nxt = S_ONE; // [R18] [R19]
               end else begin
                  st_nxt = S_RWAIT; // [R10] [R22]
               end
            end
         end
         S_ONE:    if (byte_in) st_nxt = S_HOLD;
         S_RWAIT:  if (byte_out) st_nxt = is_page_rd ? S_RDATA : S_HOLD;
         S_WDATA, S_RDATA, S_HOLD, S_REJECT: st_nxt = st_r;
      endcase
   end

   always_ff @(posedge REF_CLK) begin
      if (RST || SELECT_PIN_N) begin
         st_r <= S_PREFIX; // [R23]
      end else begin
         st_r <= st_nxt;
      end
   end

   // ==========
   // Command fields
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         code_r   <= 8'h00;
         tgt_r    <= TGT_CODE;
         hi_r     <= 8'h00;
         page_r   <= `FPP_PAGE_RST;
         offset_r <= '0;
         arm_r    <= 1'b0;
      end else begin
         if (SELECT_PIN_N) begin
            arm_r <= 1'b0;
         end
         if (st_r == S_CODE && byte_in) begin
            code_r <= COMMAND_BUS_IN;
            tgt_r  <= tgt_dec;
         end
         if (st_r == S_HI && byte_in) begin
            hi_r <= COMMAND_BUS_IN;
         end
         if (st_r == S_LO && byte_in) begin
            page_r   <= (tgt_r == TGT_CODE) ? page_dec : `FPP_PAGE_RST;
            offset_r <= is_one_wr ? '0 : off_dec; // [R04]
            // Armed at the address: an empty write still commits the buffer
            arm_r    <= (code_r != `FPP_CMD_LOAD_BUF) && !is_page_rd && (is_page_wr || is_one_wr); // [R08]
         end
         if (byte_out && ((st_r == S_WDATA && mask_r[offset_r]) || st_r == S_RDATA)) begin
            offset_r <= off_inc; // [R05] [R06] [R13]
         end
      end
   end

   // ==========
   // Last written byte, kept for data polling
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         last_tgt_r  <= TGT_CODE;
         last_page_r <= `FPP_PAGE_RST;
         last_off_r  <= '0;
         last_data_r <= 8'h00;
      end else if (data_cap) begin
         last_tgt_r  <= tgt_r;
         last_page_r <= page_r;
         last_off_r  <= cap_addr;
         last_data_r <= COMMAND_BUS_IN;
      end
   end

   // ==========
   // Drain of the page buffer into the array stream
   wire [PAGE_BYTES-1:0] scan_bit = {{(PAGE_BYTES-1){1'b0}}, 1'b1} << scan_r;
   wire commit   = sel_rise && arm_r && !busy; // [R08]
   wire drain_go = (d_st_r == D_FETCH) && buf_in_ready;
   wire [BW-1:0] buf_in = {dr_tgt_r, dr_page_r, scan_r, mem_rd_data, (mask_r & ~scan_bit) == '0};

   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         d_st_r    <= D_IDLE;
         scan_r    <= '0;
         dr_tgt_r  <= TGT_CODE;
         dr_page_r <= `FPP_PAGE_RST;
      end else begin
         unique case (d_st_r)
            D_IDLE: begin
               if (commit) begin
                  d_st_r    <= D_SCAN;
                  scan_r    <= '0;
                  dr_tgt_r  <= tgt_r;
                  dr_page_r <= page_r;
               end
            end
            D_SCAN: begin
               if (mask_r == '0) begin
                  d_st_r <= D_IDLE;
               end else if (mask_r[scan_r]) begin
                  d_st_r <= D_FETCH;
               end else begin
                  scan_r <= scan_r + 1'b1;
               end
            end
            D_FETCH: begin
               // Stalled receiver: address stays put, so read data stays valid
               if (buf_in_ready) begin
                  d_st_r <= D_SCAN;
                  scan_r <= scan_r + 1'b1;
               end
            end
            default: d_st_r <= D_IDLE;
         endcase
      end
   end

   // Loaded-byte mask; buffer stays held until a write drains it
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         mask_r <= '0;
      end else if (data_cap) begin
         mask_r <= mask_r | ({{(PAGE_BYTES-1){1'b0}}, 1'b1} << cap_addr); // [R05]
      end else if (drain_go) begin
         mask_r <= mask_r & ~scan_bit;
      end
   end

   page_buffer_mem #(
      .DEPTH (PAGE_BYTES),
      .WIDTH (8)
   ) u_mem (
      .clk     (REF_CLK),
      .wr_en   (data_cap),
      .wr_addr (cap_addr),
      .wr_data (COMMAND_BUS_IN),
      .rd_addr (scan_r),
      .rd_data (mem_rd_data)
   );

   two_entry_buffer #(
      .WIDTH (BW)
   ) u_buf (
      .clk       (REF_CLK),
      .rst       (RST),
      .in_valid  (d_st_r == D_FETCH),
      .in_ready  (buf_in_ready),
      .in_data   (buf_in),
      .out_valid (buf_out_valid),
      .out_ready (PROG_READY),
      .out_data  (buf_out)
   );

   assign PROG_VALID  = buf_out_valid;
   assign PROG_TARGET = target_e'(buf_out[BW-1 -: 3]);
   assign PROG_PAGE   = buf_out[BW-4 -: 7];
   assign PROG_OFFSET = buf_out[OW+8:9];
   assign PROG_DATA   = buf_out[8:1];
   assign PROG_LAST   = buf_out[0];

   // ==========
   // Read path and bus turnaround
   wire rd_start = byte_out && st_r == S_RWAIT; // [R11] [R22]
   wire rd_issue = (rd_start && is_page_rd) || (byte_out && st_r == S_RDATA); // [R13]
   wire poll_hit = busy && RD_TARGET == last_tgt_r && RD_PAGE == last_page_r && RD_OFFSET == last_off_r;
   wire [7:0] poll_data = {~last_data_r[`FPP_POLL_BIT], last_data_r[6:0]};
   wire [7:0] status_byte = (tgt_r == TGT_LOCK) ? LOCK_STATE : FUSE_STATE;

   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         RD_REQ          <= 1'b0;
         RD_TARGET       <= TGT_CODE;
         RD_PAGE         <= `FPP_PAGE_RST;
         RD_OFFSET       <= '0;
         rd_wait_r       <= 1'b0;
         rd_status_r     <= 1'b0;
         COMMAND_BUS_OE  <= 1'b0;
         COMMAND_BUS_OUT <= `FPP_BUS_RST;
         READY_BUSY_OUT  <= 1'b0;
      end else begin
         READY_BUSY_OUT <= !busy; // [R24]
         RD_REQ         <= rd_issue && !SELECT_PIN_N;
         rd_wait_r      <= RD_REQ;
         rd_status_r    <= rd_start && !is_page_rd;
         if (rd_issue) begin
            RD_TARGET <= tgt_r;
            RD_PAGE   <= page_r;
            RD_OFFSET <= (st_r == S_RDATA) ? off_inc : offset_r;
         end
         if (SELECT_PIN_N) begin
            COMMAND_BUS_OE <= 1'b0; // [R23]
         end else if (rd_start) begin
            COMMAND_BUS_OE <= 1'b1; // [R11] [R12]
         end
         if (rd_wait_r) begin
            COMMAND_BUS_OUT <= poll_hit ? poll_data : RD_DATA; // [R25] [R16] [R17]
         end else if (rd_status_r) begin
            COMMAND_BUS_OUT <= status_byte; // [R22]
         end
      end
   end

endmodule : flash_prog_port

`default_nettype wire

// *** hdl/flash_prog_map.svh ***
// Command codes, field positions and reset values of the parallel programming port
`ifndef FLASH_PROG_MAP_SVH
`define FLASH_PROG_MAP_SVH

// ==========
// Command bytes
`define FPP_PREFIX          8'hAA
`define FPP_CMD_WR_CODE     8'h50
`define FPP_CMD_LOAD_BUF    8'h51
`define FPP_CMD_WR_USER     8'h52
`define FPP_CMD_RD_CODE     8'h30
`define FPP_CMD_RD_USER     8'h32
`define FPP_CMD_RD_MAKER    8'h38
`define FPP_CMD_WR_LOCK     8'hE4
`define FPP_CMD_WR_FUSE     8'hE1
`define FPP_CMD_RD_LOCK     8'h64
`define FPP_CMD_RD_FUSE     8'h61

// ==========
// Address field positions and data polling bit
`define FPP_PAGE_HI_MSB     3
`define FPP_PAGE_LO_LSB     5
`define FPP_POLL_BIT        7

// ==========
// Reset values
`define FPP_BUS_RST         8'h00
`define FPP_PAGE_RST        7'h00

`endif

// *** hdl/flash_prog_pkg.sv ***
// Types shared by the parallel programming port and its helpers
package flash_prog_pkg;

   // Array region that a transfer addresses
   typedef enum logic [2:0] {
      TGT_CODE,
      TGT_USER,
      TGT_MAKER,
      TGT_LOCK,
      TGT_FUSE
   } target_e;

   // Byte-sequence position of the command interpreter
   typedef enum logic [3:0] {
      S_PREFIX,
      S_CODE,
      S_HI,
      S_LO,
      S_WDATA,
      S_ONE,
      S_RWAIT,
      S_RDATA,
      S_HOLD,
      S_REJECT
   } cmd_state_e;

   // Page buffer drain sequencer
   typedef enum logic [1:0] {
      D_IDLE,
      D_SCAN,
      D_FETCH
   } drain_state_e;

endpackage : flash_prog_pkg

// *** hdl/page_buffer_mem.sv ***
// Page buffer storage with registered read data
`timescale 1ns/100ps
`default_nettype none

module page_buffer_mem #(
   parameter int DEPTH = 32,
   parameter int WIDTH = 8
) (
   input  wire logic                     clk,
   input  wire logic                     wr_en,
   input  wire logic [$clog2(DEPTH)-1:0] wr_addr,
   input  wire logic [WIDTH-1:0]         wr_data,
   input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
   output var  logic [WIDTH-1:0]         rd_data
);

   logic [WIDTH-1:0] mem [DEPTH];

   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
   end

endmodule : page_buffer_mem

`default_nettype wire

// *** hdl/two_entry_buffer.sv ***
// Two-entry buffer with valid/ready on both sides and registered outputs
`timescale 1ns/100ps
`default_nettype none

module two_entry_buffer #(
   parameter int WIDTH = 24
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             in_valid,
   output var  logic             in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output var  logic             out_valid,
   input  wire logic             out_ready,
   output var  logic [WIDTH-1:0] out_data
);

   logic             v1_r;
   logic [WIDTH-1:0] e1_r;

   wire push = in_valid && in_ready;
   wire pop  = out_valid && out_ready;

   // Ready comes from a register so the source never sees a combinational path
   always_ff @(posedge clk) begin
      if (rst) begin
         out_valid <= 1'b0;
         v1_r      <= 1'b0;
         in_ready  <= 1'b1;
         out_data  <= '0;
         e1_r      <= '0;
      end else begin
         unique case ({push, pop})
            2'b10: begin
               if (!out_valid) begin
                  out_valid <= 1'b1;
                  out_data  <= in_data;
               end else begin
                  v1_r     <= 1'b1;
                  e1_r     <= in_data;
                  in_ready <= 1'b0;
               end
            end
            2'b01: begin
               out_valid <= v1_r;
               out_data  <= e1_r;
               v1_r      <= 1'b0;
               in_ready  <= 1'b1;
            end
            2'b11: begin
               if (v1_r) begin
                  out_data <= e1_r;
                  e1_r     <= in_data;
               end else begin
                  out_data <= in_data;
               end
            end
            default: begin
            end
         endcase
      end
   end

endmodule : two_entry_buffer

`default_nettype wire

// *** dv/flash_prog_properties.sv ***
// Concurrent checks on the ports of the parallel programming port
`timescale 1ns/100ps
`default_nettype none

module flash_prog_properties
   import flash_prog_pkg::*;
#(
   parameter int PAGE_BYTES = 32,
   parameter int OW         = $clog2(PAGE_BYTES)
) (
   input wire logic          REF_CLK,
   input wire logic          RST,
   input wire logic          SELECT_PIN_N,
   input wire logic          ARRAY_BUSY,
   input wire logic          COMMAND_BUS_OE,
   input wire logic [7:0]    COMMAND_BUS_OUT,
   input wire logic          READY_BUSY_OUT,
   input wire logic          RD_REQ,
   input wire logic [OW-1:0] RD_OFFSET,
   input wire logic [7:0]    RD_DATA,
   input wire logic          PROG_VALID,
   input wire logic          PROG_READY,
   input wire target_e       PROG_TARGET,
   input wire logic [6:0]    PROG_PAGE,
   input wire logic [OW-1:0] PROG_OFFSET,
   input wire logic [7:0]    PROG_DATA
);
   // ==========
   // Helper: expected offset of the next read in this selection
   logic          rd_seen_r;
   logic [OW-1:0] exp_off_r;
   always_ff @(posedge REF_CLK) begin
      if (RST || SELECT_PIN_N) rd_seen_r <= 1'b0;
      else if (RD_REQ) rd_seen_r <= 1'b1;
      if (RD_REQ) exp_off_r <= RD_OFFSET + 1'b1;
   end

   default clocking @(posedge REF_CLK); endclocking
   default disable iff (RST);

   // ==========
   // Sequences
   sequence idle_sel;
      SELECT_PIN_N [*3];
   endsequence
   // Clean read: no polling inversion can apply
   sequence req_then_wait;
      RD_REQ && READY_BUSY_OUT && !ARRAY_BUSY ##1 1'b1;
   endsequence

   // ==========
   // Assertions
   bus_release_a: assert property (idle_sel |-> !COMMAND_BUS_OE)
      else $error("bus driven idle");
   req_idle_a: assert property (idle_sel |-> !RD_REQ)
      else $error("read while idle");
   busy_pin_a: assert property (ARRAY_BUSY [*2] |-> !READY_BUSY_OUT)
      else $error("ready while busy");
   stream_busy_a: assert property (PROG_VALID |-> !READY_BUSY_OUT)
      else $error("ready while words wait");
   read_drive_a: assert property (RD_REQ |-> COMMAND_BUS_OE)
      else $error("read not driven");
   rd_step_a: assert property (RD_REQ && rd_seen_r |-> RD_OFFSET == exp_off_r)
      else $error("read offset skipped");
   rd_pulse_a: assert property (RD_REQ |=> !RD_REQ)
      else $error("read request too long");
   rd_return_a: assert property (req_then_wait |=> COMMAND_BUS_OUT == $past(RD_DATA))
      else $error("read byte missing");
   hold_word_a: assert property (PROG_VALID && !PROG_READY |=>
      PROG_VALID && $stable(PROG_DATA) && $stable(PROG_OFFSET) && $stable(PROG_TARGET))
      else $error("word moved while stalled");
   row_page_a: assert property (PROG_VALID && PROG_TARGET != TGT_CODE |-> PROG_PAGE == 7'h00)
      else $error("row page nonzero");
endmodule : flash_prog_properties

bind flash_prog_port flash_prog_properties #(.PAGE_BYTES(PAGE_BYTES)) props (.*);

`default_nettype wire

// *** dv/prog_host_model.sv ***
// Behavioural programmer driving select, strobe and the command bus
`timescale 1ns/100ps
`default_nettype none

module prog_host_model (
   input  wire logic       clk,
   input  wire logic [7:0] dev_out,
   input  wire logic       dev_oe,
   output var  logic       sel_n,
   output var  logic       strobe,
   output wire logic [7:0] bus
);
   logic [7:0] d_r;
   logic       drv_r;
   // Undriven bus shows the inverse of the last byte, never a stale copy
   assign bus = dev_oe ? dev_out : (drv_r ? d_r : ~d_r);
   initial begin
      sel_n = 1'b1;
      strobe = 1'b0;
      d_r = 8'h00;
      drv_r = 1'b0;
   end
   task open_cmd;
      @(posedge clk) sel_n <= 1'b0;
      repeat (2) @(posedge clk);
   endtask : open_cmd
   task close_cmd;
      @(posedge clk) sel_n <= 1'b1;
      drv_r <= 1'b0;
      repeat (3) @(posedge clk);
   endtask : close_cmd
   // Byte set up one clock ahead of the rise, strobe high and low two clocks each
   task put(input logic [7:0] b, input logic rel);
      @(posedge clk) d_r <= b;
      drv_r <= 1'b1;
      @(posedge clk) strobe <= 1'b1;
      @(posedge clk) if (rel) drv_r <= 1'b0;
      @(posedge clk) strobe <= 1'b0;
      repeat (2) @(posedge clk);
   endtask : put
   task pulse;
      @(posedge clk) strobe <= 1'b1;
      repeat (2) @(posedge clk);
      strobe <= 1'b0;
      repeat (2) @(posedge clk);
   endtask : pulse
   task get(output logic [7:0] b);
      repeat (6) @(posedge clk);
      @(negedge clk) b = bus;
   endtask : get
endmodule : prog_host_model

`default_nettype wire

// *** dv/flash_prog_port_bench.sv ***
// Self-checking bench of the parallel programming port
`timescale 1ns/100ps
`default_nettype none

module flash_prog_port_bench;
   import flash_prog_pkg::*;
   logic        ref_clk, rst, array_busy, prog_ready, sel_n, strobe, rd_req, prog_valid, prog_last, bus_oe, rdy;
   logic [7:0]  bus_out, rd_data, lock_state, fuse_state, prog_data;
   wire logic [7:0] bus;
   target_e     rd_tgt, prog_tgt;
   logic [6:0]  rd_page, prog_page;
   logic [4:0]  rd_off, prog_off;
   logic [1:0]  stall_r;
   logic [23:0] q[$];
   int          fail_count, n_checks;

   prog_host_model p (.clk(ref_clk), .dev_out(bus_out), .dev_oe(bus_oe), .sel_n(sel_n), .strobe(strobe), .bus(bus));
   flash_prog_port #(.PAGE_BYTES(32)) uut (.REF_CLK(ref_clk), .RST(rst), .SELECT_PIN_N(sel_n), .BYTE_STROBE(strobe),
      .COMMAND_BUS_IN(bus), .COMMAND_BUS_OUT(bus_out), .COMMAND_BUS_OE(bus_oe), .READY_BUSY_OUT(rdy),
      .ARRAY_BUSY(array_busy), .RD_REQ(rd_req), .RD_TARGET(rd_tgt), .RD_PAGE(rd_page), .RD_OFFSET(rd_off),
      .RD_DATA(rd_data), .LOCK_STATE(lock_state), .FUSE_STATE(fuse_state), .PROG_VALID(prog_valid),
      .PROG_READY(prog_ready), .PROG_TARGET(prog_tgt), .PROG_PAGE(prog_page), .PROG_OFFSET(prog_off),
      .PROG_DATA(prog_data), .PROG_LAST(prog_last));

   // ==========
   // Array side
   function automatic logic [7:0] arr(target_e t, logic [6:0] pg, logic [4:0] o);
      return {o, t} ^ {pg, 1'b0};
   endfunction : arr
   always @(posedge ref_clk) begin
      stall_r <= stall_r + 2'd1;
      prog_ready <= stall_r[1];
      if (rd_req) rd_data <= arr(rd_tgt, rd_page, rd_off);
      if (prog_valid && prog_ready) q.push_back({prog_tgt, prog_page, prog_off, prog_data, prog_last});
   end

   // ==========
   // Shared tasks
   task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] seen);
      n_checks++;
      if (seen !== exp) begin
         $display("BAD %s expected %h seen %h", what, exp, seen);
         fail_count++;
      end
   endtask : chk
   task automatic take(input logic [23:0] exp);
      for (int i = 0; i < 300 && q.size() == 0; i++) @(posedge ref_clk);
      chk("word", exp, (q.size() > 0) ? q.pop_front() : 24'hxx_xxxx);
   endtask : take
   task automatic wait_ready;
      for (int i = 0; i < 300 && rdy !== 1'b1; i++) @(posedge ref_clk);
      chk("ready", 24'h00_0001, 24'(rdy));
   endtask : wait_ready
   task automatic send(input logic [7:0] c, input logic [7:0] h, input logic [7:0] l, input logic rd);
      p.open_cmd;
      p.put(8'hAA, 1'b0);
      p.put(c, 1'b0);
      p.put(h, 1'b0);
      p.put(l, rd);
   endtask : send

   // ==========
   // Scenarios
   task automatic t_rd_code;
      logic [7:0] b;
      send(8'h30, 8'h05, 8'hBE, 1'b1);
      for (int i = 0; i < 4; i++) begin
         if (i > 0) p.pulse;
         p.get(b);
         chk("code read", 24'(arr(TGT_CODE, 7'h2D, 5'(30 + i))), 24'(b));
      end
      p.close_cmd;
   endtask : t_rd_code
   task automatic t_rd_rows;
      logic [7:0] b;
      for (int k = 0; k < 2; k++) begin
         send(k ? 8'h38 : 8'h32, 8'h00, 8'h1F, 1'b1);
         p.get(b);
         chk("row read", 24'(arr(k ? TGT_MAKER : TGT_USER, 7'h00, 5'd31)), 24'(b));
         p.pulse;
         p.get(b);
         chk("row read", 24'(arr(k ? TGT_MAKER : TGT_USER, 7'h00, 5'd0)), 24'(b));
         p.close_cmd;
      end
   endtask : t_rd_rows
   task automatic t_wr_code;
      send(8'h50, 8'h0A, 8'h5F, 1'b0);
      for (int i = 0; i < 3; i++) p.put(8'(8'h11 * (i + 1)), 1'b0);
      p.close_cmd;
      for (int i = 0; i < 3; i++) take({TGT_CODE, 7'h52, 5'(i == 2 ? 31 : i), 8'(8'h11 * ((i + 1) % 3 + 1)), i == 2});
      wait_ready;
   endtask : t_wr_code
   task automatic t_wr_user;
      send(8'h52, 8'h00, 8'h05, 1'b0);
      p.put(8'hC3, 1'b0);
      p.put(8'h3C, 1'b0);
      p.close_cmd;
      take({TGT_USER, 7'h00, 5'd5, 8'hC3, 1'b0});
      take({TGT_USER, 7'h00, 5'd6, 8'h3C, 1'b1});
      wait_ready;
      send(8'h51, 8'h00, 8'h07, 1'b0);
      p.put(8'h5A, 1'b0);
      p.close_cmd;
      send(8'h50, 8'h01, 8'h20, 1'b0);
      p.close_cmd;
      take({TGT_CODE, 7'h09, 5'd7, 8'h5A, 1'b1});
      repeat (60) @(posedge ref_clk);
      chk("extra words", 24'h00_0000, 24'(q.size()));
   endtask : t_wr_user
   task automatic t_lock_fuse;
      logic [7:0] b;
      for (int k = 0; k < 2; k++) begin
         send(k ? 8'hE1 : 8'hE4, 8'h00, 8'h00, 1'b0);
         p.put(k ? 8'hF5 : 8'h03, 1'b0);
         p.close_cmd;
         take({k ? TGT_FUSE : TGT_LOCK, 7'h00, 5'd0, k ? 8'hF5 : 8'h03, 1'b1});
         wait_ready;
         send(k ? 8'h61 : 8'h64, 8'h00, 8'h00, 1'b1);
         p.get(b);
         chk("status read", 24'(k ? fuse_state : lock_state), 24'(b));
         p.close_cmd;
      end
   endtask : t_lock_fuse
   task automatic t_reject;
      logic [7:0] b;
      p.open_cmd;
      p.put(8'h55, 1'b0);
      p.put(8'h30, 1'b0);
      p.put(8'h00, 1'b0);
      p.put(8'h00, 1'b1);
      p.get(b);
      chk("reject drive", 24'h00_0000, 24'(bus_oe));
      p.close_cmd;
   endtask : t_reject
   task automatic t_busy;
      @(posedge ref_clk) array_busy <= 1'b1;
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk) chk("busy pin", 24'h00_0000, 24'(rdy));
      @(posedge ref_clk) array_busy <= 1'b0;
      wait_ready;
   endtask : t_busy

   task tally_and_finish;
      if (fail_count == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : tally_and_finish

   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   initial begin
      repeat (20000) @(posedge ref_clk);
      fail_count++;
      tally_and_finish();
   end
   initial begin
      rst = 1'b1;
      array_busy = 1'b0;
      prog_ready = 1'b0;
      stall_r = 2'd0;
      rd_data = 8'h00;
      lock_state = 8'hFC;
      fuse_state = 8'hA5;
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      repeat (2) @(posedge ref_clk);
      t_rd_code();
      t_rd_rows();
      t_wr_code();
      t_wr_user();
      t_lock_fuse();
      t_reject();
      t_busy();
      tally_and_finish();
   end
endmodule : flash_prog_port_bench

`default_nettype wire
